/* File: diag_pkg.sv */
// Constants for the diagnostic live status and threshold register bank
// Summary of operation
// RULE1: Register 0x41 bit 7 shows channel 2 positive output short, live.
// RULE2: Register 0x41 bit 6 shows channel 2 negative output short, live.
// RULE3: Register 0x41 bit 5 shows positive-side driver virtual ground fault.
// RULE4: Register 0x41 bit 4 shows negative-side driver virtual ground fault.
// RULE5: Register 0x41 bit 0 shows regulator short; bits 3 to 1 read zero.
// RULE6: Register 0x42 bit 3 shows headset insertion, live.
// RULE7: Register 0x42 bit 2 shows headset removal, live.
// RULE8: Register 0x42 bit 1 shows headset hook button press, live.
// RULE9: Register 0x43 bit 7 shows analog input above upper threshold.
// RULE10: Register 0x43 bit 6 shows analog input below lower threshold.
// RULE11: Upper threshold code, 8-bit read/write, resets to 0xba.
// RULE12: Lower threshold code, 8-bit read/write, resets to 0x4b.
// RULE13: Bits 6 to 5 of 0x54 select supply filter, reset 2.
// RULE14: Bits 3 to 2 of 0x54 select battery filter, reset 2.
// RULE15: Software writes only reset values into reserved bits.
// RULE16: Each live event has a latched twin that clears once read; the code latches only the 0x42 and 0x43 bits.
// RULE17: Live bits follow the condition without latching; writes ignored.
// RULE18: Analog samples compare against threshold codes scaled by 16.
package diag_pkg;
  localparam logic [7:0] ADDR_HS_LATCH  = 8'h3a;
  localparam logic [7:0] ADDR_THR_LATCH = 8'h3b;
  localparam logic [7:0] ADDR_OUT_LIVE  = 8'h41;
  localparam logic [7:0] ADDR_HS_LIVE   = 8'h42;
  localparam logic [7:0] ADDR_THR_LIVE  = 8'h43;
  localparam logic [7:0] ADDR_UPPER     = 8'h4e;
  localparam logic [7:0] ADDR_LOWER     = 8'h4f;
  localparam logic [7:0] ADDR_FILTER    = 8'h54;
  localparam logic [7:0] ADDR_DATA_CFG  = 8'h55;
  localparam logic [7:0] RST_UPPER      = 8'hba;
  localparam logic [7:0] RST_LOWER      = 8'h4b;
  localparam logic [7:0] RST_FILTER     = 8'h48;
  localparam logic [7:0] RST_DATA_CFG   = 8'h00;
  localparam logic [7:0] FILTER_WMASK   = 8'h7f;
  localparam int         SUPPLY_LSB     = 5;
  localparam int         BATTERY_LSB    = 2;
  localparam int         HS_INS_BIT     = 3;
  localparam int         HS_REM_BIT     = 2;
  localparam int         HS_HOOK_BIT    = 1;
  localparam int         UP_BIT         = 7;
  localparam int         LOW_BIT        = 6;
  localparam int         THR_SHIFT      = 4;
endpackage : diag_pkg

/* File: diag_live_status_threshold_regs.sv */
// Live diagnostic status, latched events and threshold configuration bank
`timescale 1ns/100ps
module diag_live_status_threshold_regs (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        ch2_pos_output_short,
  input  wire logic        ch2_neg_output_short,
  input  wire logic        pos_side_driver_vg_fault,
  input  wire logic        neg_side_driver_vg_fault,
  input  wire logic        regulator_short_live,
  input  wire logic        headset_insert,
  input  wire logic        headset_remove,
  input  wire logic        headset_hook,
  input  wire logic [11:0] general_analog_sample,
  input  wire logic        general_analog_valid,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  output logic      [1:0]  supply_filter_select,
  output logic      [1:0]  battery_filter_select,
  output logic      [7:0]  monitor_data_config
);
  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic       above;
    logic       below;
    logic [7:0] upper;
    logic [7:0] lower;
    logic [7:0] filt;
    logic [7:0] dcfg;
    logic [7:0] hs_latch;
    logic [7:0] thr_latch;
    logic [7:0] rdata;
    logic       rvalid;
  } state_t;

  localparam state_t RST_STATE = '{
    sync1:     8'h00,
    sync2:     8'h00,
    above:     1'b0,
    below:     1'b0,
    upper:     diag_pkg::RST_UPPER,
    lower:     diag_pkg::RST_LOWER,
    filt:      diag_pkg::RST_FILTER,
    dcfg:      diag_pkg::RST_DATA_CFG,
    hs_latch:  8'h00,
    thr_latch: 8'h00,
    rdata:     8'h00,
    rvalid:    1'b0
  };

  state_t     q;
  state_t     d;
  logic [7:0] out_live;
  logic [7:0] hs_live;
  logic [7:0] thr_live;
  logic [7:0] pins;
  logic [11:0] up_lim;
  logic [11:0] low_lim;

  // Pins are asynchronous to the control clock, so every one is synchronised
  assign pins = {ch2_pos_output_short, ch2_neg_output_short,
                 pos_side_driver_vg_fault, neg_side_driver_vg_fault,
                 regulator_short_live, headset_insert, headset_remove,
                 headset_hook};

  // Live views are pure wiring of current state, nothing is held
  always_comb begin
    out_live = {q.sync2[7:4], 3'h0, q.sync2[3]}; // RULE1 RULE2 RULE3 RULE4 RULE5 RULE17
    hs_live = 8'h00;
    hs_live[diag_pkg::HS_INS_BIT] = q.sync2[2]; // RULE6
    hs_live[diag_pkg::HS_REM_BIT] = q.sync2[1]; // RULE7
    hs_live[diag_pkg::HS_HOOK_BIT] = q.sync2[0]; // RULE8
    thr_live = 8'h00;
    thr_live[diag_pkg::UP_BIT] = q.above; // RULE9
    thr_live[diag_pkg::LOW_BIT] = q.below; // RULE10
  end

  // Codes are 8-bit; the sample is 12-bit, so codes move up four places
  assign up_lim  = 12'(q.upper) << diag_pkg::THR_SHIFT; // RULE18
  assign low_lim = 12'(q.lower) << diag_pkg::THR_SHIFT; // RULE18

  always_comb begin
    d = q;
    d.sync1 = pins;
    d.sync2 = q.sync1;
    if (general_analog_valid) begin
      d.above = general_analog_sample > up_lim; // RULE18
      d.below = general_analog_sample < low_lim; // RULE18
    end
    // Set wins over the clear on read, so no event is lost in that cycle
    d.hs_latch = q.hs_latch;
    d.thr_latch = q.thr_latch;
    if (reg_rd && reg_addr == diag_pkg::ADDR_HS_LATCH) begin
      d.hs_latch = 8'h00; // RULE16
    end
    if (reg_rd && reg_addr == diag_pkg::ADDR_THR_LATCH) begin
      d.thr_latch = 8'h00; // RULE16
    end
    d.hs_latch = d.hs_latch | hs_live; // RULE16
    d.thr_latch = d.thr_latch | thr_live; // RULE16
    if (reg_wr) begin
      // Live and latched registers are read-only; writes there fall away
      case (reg_addr)
        diag_pkg::ADDR_UPPER: begin
          d.upper = reg_wdata; // RULE11
        end
        diag_pkg::ADDR_LOWER: begin
          d.lower = reg_wdata; // RULE12
        end
        diag_pkg::ADDR_FILTER: begin
          d.filt = reg_wdata & diag_pkg::FILTER_WMASK; // RULE13 RULE14
        end
        diag_pkg::ADDR_DATA_CFG: begin
          d.dcfg = reg_wdata;
        end
        default: begin
          d.dcfg = q.dcfg; // RULE17
        end
      endcase
    end
    d.rvalid = reg_rd;
    if (reg_rd) begin
      case (reg_addr)
        diag_pkg::ADDR_HS_LATCH:  d.rdata = q.hs_latch;
        diag_pkg::ADDR_THR_LATCH: d.rdata = q.thr_latch;
        diag_pkg::ADDR_OUT_LIVE:  d.rdata = out_live;
        diag_pkg::ADDR_HS_LIVE:   d.rdata = hs_live;
        diag_pkg::ADDR_THR_LIVE:  d.rdata = thr_live;
        diag_pkg::ADDR_UPPER:     d.rdata = q.upper;
        diag_pkg::ADDR_LOWER:     d.rdata = q.lower;
        diag_pkg::ADDR_FILTER:    d.rdata = q.filt;
        diag_pkg::ADDR_DATA_CFG:  d.rdata = q.dcfg;
        default:                  d.rdata = 8'h00;
      endcase
    end
  end

  // Clock enable low freezes every flop, synchronisers included
  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= RST_STATE;
    end else if (ce) begin
      q <= d;
    end
  end

  assign reg_rdata             = q.rdata;
  assign reg_rvalid            = q.rvalid;
  assign supply_filter_select  = q.filt[diag_pkg::SUPPLY_LSB +: 2]; // RULE13
  assign battery_filter_select = q.filt[diag_pkg::BATTERY_LSB +: 2]; // RULE14
  assign monitor_data_config   = q.dcfg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_fault_read_live: assert property ( // RULE1
    ce && reg_rd && reg_addr == diag_pkg::ADDR_OUT_LIVE
    |=> reg_rvalid && reg_rdata[7:4] == $past(q.sync2[7:4]))
    else $error("channel 2 fault bits wrong on read");
  a_fault_reg_reserved: assert property ( // RULE5
    ce && reg_rd && reg_addr == diag_pkg::ADDR_OUT_LIVE
    |=> reg_rdata[3:1] == 3'h0 && reg_rdata[0] == $past(q.sync2[3]))
    else $error("regulator bit or reserved bits wrong");
  a_pin_to_read: assert property ( // RULE2
    ce [*3] ##0 (ch2_neg_output_short == $past(ch2_neg_output_short, 2))
    ##0 reg_rd && reg_addr == diag_pkg::ADDR_OUT_LIVE
    |=> reg_rdata[6] == $past(ch2_neg_output_short, 3))
    else $error("negative short does not reach the register");
  a_headset_read: assert property ( // RULE6
    ce && reg_rd && reg_addr == diag_pkg::ADDR_HS_LIVE
    |=> reg_rdata == {4'h0, $past(q.sync2[2:0]), 1'b0})
    else $error("headset live bits misplaced");
  a_thr_read: assert property ( // RULE9
    ce && reg_rd && reg_addr == diag_pkg::ADDR_THR_LIVE
    |=> reg_rdata == {$past(q.above), $past(q.below), 6'h00})
    else $error("threshold live bits wrong");
  a_upper_wr_rd: assert property ( // RULE11
    ce && reg_wr && reg_addr == diag_pkg::ADDR_UPPER ##1
    ce && reg_rd && !reg_wr && reg_addr == diag_pkg::ADDR_UPPER
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("upper threshold not stored");
  a_lower_wr_rd: assert property ( // RULE12
    ce && reg_wr && reg_addr == diag_pkg::ADDR_LOWER ##1
    ce && reg_rd && !reg_wr && reg_addr == diag_pkg::ADDR_LOWER
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("lower threshold not stored");
  a_filter_fields: assert property ( // RULE13
    ce && reg_wr && reg_addr == diag_pkg::ADDR_FILTER
    |=> supply_filter_select == $past(reg_wdata[6:5]) &&
        battery_filter_select == $past(reg_wdata[3:2]))
    else $error("filter select fields wrong");
  a_latch_clear_read: assert property ( // RULE16
    ce && reg_rd && reg_addr == diag_pkg::ADDR_HS_LATCH && hs_live == 8'h00
    |=> q.hs_latch == 8'h00 ##1
        q.hs_latch == ($past(ce) ? $past(hs_live) : 8'h00))
    else $error("latched headset bits not cleared by read");
  a_latch_set_wins: assert property ( // RULE16
    ce && thr_live != 8'h00 |=> (q.thr_latch & $past(thr_live)) ==
    $past(thr_live))
    else $error("threshold event lost");
  a_live_ro_write: assert property ( // RULE17
    ce && reg_wr && reg_addr == diag_pkg::ADDR_OUT_LIVE
    |=> q.upper == $past(q.upper) && q.filt == $past(q.filt))
    else $error("write to live register changed state");
  a_cmp_above: assert property ( // RULE18
    ce && general_analog_valid && general_analog_sample > {q.upper, 4'h0}
    |=> q.above)
    else $error("upper comparison missed");
  a_cmp_below: assert property ( // RULE10
    ce && general_analog_valid && general_analog_sample >= {q.lower, 4'h0}
    |=> !q.below)
    else $error("lower flag set without cause");

  // Pin to register, through both synchroniser stages
  a_pos_short_pin: assert property ( // RULE1
    ce [*3] ##0 reg_rd && reg_addr == diag_pkg::ADDR_OUT_LIVE
    |=> reg_rdata[7] == $past(ch2_pos_output_short, 3))
    else $error("positive short does not reach the register");
  a_pos_vg_pin: assert property ( // RULE3
    ce [*3] ##0 reg_rd && reg_addr == diag_pkg::ADDR_OUT_LIVE
    |=> reg_rdata[5] == $past(pos_side_driver_vg_fault, 3))
    else $error("positive driver ground fault does not reach the register");
  a_neg_vg_pin: assert property ( // RULE4
    ce [*3] ##0 reg_rd && reg_addr == diag_pkg::ADDR_OUT_LIVE
    |=> reg_rdata[4] == $past(neg_side_driver_vg_fault, 3))
    else $error("negative driver ground fault does not reach the register");
  a_regulator_pin: assert property ( // RULE5
    ce [*3] ##0 reg_rd && reg_addr == diag_pkg::ADDR_OUT_LIVE
    |=> reg_rdata[0] == $past(regulator_short_live, 3))
    else $error("regulator short does not reach the register");
  a_insert_pin: assert property ( // RULE6
    ce [*3] ##0 reg_rd && reg_addr == diag_pkg::ADDR_HS_LIVE
    |=> reg_rdata[3] == $past(headset_insert, 3))
    else $error("headset insertion does not reach the register");
  a_remove_pin: assert property ( // RULE7
    ce [*3] ##0 reg_rd && reg_addr == diag_pkg::ADDR_HS_LIVE
    |=> reg_rdata[2] == $past(headset_remove, 3))
    else $error("headset removal does not reach the register");
  a_hook_pin: assert property ( // RULE8
    ce [*3] ##0 reg_rd && reg_addr == diag_pkg::ADDR_HS_LIVE
    |=> reg_rdata[1] == $past(headset_hook, 3))
    else $error("hook press does not reach the register");

  // Reset values seen at the first edge out of reset
  a_upper_reset: assert property ( // RULE11
    $fell(rst) |-> q.upper == diag_pkg::RST_UPPER)
    else $error("upper threshold reset value wrong");
  a_lower_reset: assert property ( // RULE12
    $fell(rst) |-> q.lower == diag_pkg::RST_LOWER)
    else $error("lower threshold reset value wrong");
  a_supply_reset: assert property ( // RULE13
    $fell(rst) |-> supply_filter_select == diag_pkg::RST_FILTER[6:5])
    else $error("supply filter reset value wrong");
  a_battery_reset: assert property ( // RULE14
    $fell(rst) |-> battery_filter_select == diag_pkg::RST_FILTER[3:2])
    else $error("battery filter reset value wrong");
  a_filter_top_bit: assert property ( // RULE13
    ce && reg_wr && reg_addr == diag_pkg::ADDR_FILTER
    |=> !q.filt[7])
    else $error("reserved filter bit took a write");

  // Latched twins and read-only protection
  a_thr_latch_read: assert property ( // RULE16
    ce && reg_rd && reg_addr == diag_pkg::ADDR_THR_LATCH
    |=> reg_rdata == $past(q.thr_latch) && q.thr_latch == $past(thr_live))
    else $error("threshold latch read or clear wrong");
  a_hs_latch_read: assert property ( // RULE16
    ce && reg_rd && reg_addr == diag_pkg::ADDR_HS_LATCH
    |=> reg_rdata == $past(q.hs_latch) && q.hs_latch == $past(hs_live))
    else $error("headset latch read or clear wrong");
  a_hs_ro_write: assert property ( // RULE17
    ce && reg_wr && reg_addr == diag_pkg::ADDR_HS_LIVE
    |=> q.lower == $past(q.lower) && q.dcfg == $past(q.dcfg))
    else $error("write to headset live register changed state");
  a_thr_ro_write: assert property ( // RULE17
    ce && reg_wr && reg_addr == diag_pkg::ADDR_THR_LIVE
    |=> q.upper == $past(q.upper) && q.filt == $past(q.filt))
    else $error("write to threshold live register changed state");

  // Comparator and clock enable
  a_cmp_not_above: assert property ( // RULE9
    ce && general_analog_valid && general_analog_sample <= {q.upper, 4'h0}
    |=> !q.above)
    else $error("upper flag set without cause");
  a_cmp_below_set: assert property ( // RULE10
    ce && general_analog_valid && general_analog_sample < {q.lower, 4'h0}
    |=> q.below)
    else $error("lower comparison missed");
  a_cmp_hold: assert property ( // RULE18
    ce && !general_analog_valid
    |=> q.above == $past(q.above) && q.below == $past(q.below))
    else $error("threshold flags moved without a sample");
  a_freeze_hold: assert property (
    !ce |=> q == $past(q))
    else $error("state moved while clock enable was low");
  a_rvalid_pulse: assert property (
    ce && !reg_rd |=> !reg_rvalid)
    else $error("read valid without a read");

  c_short_seen: cover property (
    ce && reg_rd && reg_addr == diag_pkg::ADDR_OUT_LIVE ##1 reg_rdata[7]);
  c_latch_read: cover property (
    ce && reg_rd && reg_addr == diag_pkg::ADDR_HS_LATCH && hs_live != 8'h00);
  c_above_seen: cover property (q.above ##1 !q.above);
  c_filter_wr: cover property (
    ce && reg_wr && reg_addr == diag_pkg::ADDR_FILTER);
  c_frozen_write: cover property (!ce && reg_wr);
endmodule : diag_live_status_threshold_regs

/* File: diag_pin_source.sv */
// Far-side model of the fault pins and the monitor converter samples
`timescale 1ns/100ps
module diag_pin_source (
  input  wire logic        core_clk,
  input  wire logic [7:0]  cmd_pins,
  input  wire logic [11:0] cmd_sample,
  input  wire logic        cmd_fire,
  output logic      [7:0]  pins = 8'h00,
  output logic      [11:0] sample = 12'h000,
  output logic             valid = 1'b0
);
  // Levels change just after an edge, as a real front end would
  always @(posedge core_clk) begin
    pins <= cmd_pins;
    valid <= cmd_fire;
    // Between valid pulses the sample bus carries junk, not the last value
    sample <= cmd_fire ? cmd_sample : ~cmd_sample;
  end
endmodule : diag_pin_source

/* File: diag_live_status_threshold_regs_tb_top.sv */
// Self-checking bench for the diagnostic live status register bank
`timescale 1ns/100ps
module diag_live_status_threshold_regs_tb_top;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, cmd_pins = 8'h00;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, cmd_fire = 1'b0, ce = 1'b1;
  logic [11:0] cmd_sample = 12'h000, sample;
  logic [7:0]  pins, reg_rdata, dcfg_o, p;
  logic        valid, reg_rvalid;
  logic [1:0]  sup_o, bat_o;
  int fails = 0, checks_done = 0, seed = 32'h275655f4;
  int up = 8'hba, lo = 8'h4b, flt, dcfg, thr = 0, lat_hs = 0, lat_thr = 0;
  int s, i;
  diag_pin_source u_diag_pin_source (.core_clk(core_clk),
    .cmd_pins(cmd_pins), .cmd_sample(cmd_sample), .cmd_fire(cmd_fire),
    .pins(pins), .sample(sample), .valid(valid));
  diag_live_status_threshold_regs u_diag_live_status_threshold_regs (
    .core_clk(core_clk), .rst(rst), .ce(ce),
    .ch2_pos_output_short(pins[7]), .ch2_neg_output_short(pins[6]),
    .pos_side_driver_vg_fault(pins[5]), .neg_side_driver_vg_fault(pins[4]),
    .regulator_short_live(pins[3]), .headset_insert(pins[2]),
    .headset_remove(pins[1]), .headset_hook(pins[0]),
    .general_analog_sample(sample), .general_analog_valid(valid),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .supply_filter_select(sup_o), .battery_filter_select(bat_o),
    .monitor_data_config(dcfg_o));
  initial forever #12.5 core_clk = ~core_clk;
  task automatic report_and_stop();
    if (fails == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Write, then read the same address on the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rvalid", 8'h01, {7'h00, reg_rvalid});
    chk("reg_rdata", d, reg_rdata);
  endtask : wr_rd
  // Answer is registered at the taking edge and stands just after it
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rvalid", 8'h01, {7'h00, reg_rvalid});
    chk("reg_rdata", e, reg_rdata);
  endtask : rd
  task automatic setpins(input logic [7:0] v);
    @(posedge core_clk);
    cmd_pins <= v;
    repeat (5) @(posedge core_clk);
    lat_hs = lat_hs | {v[2:0], 1'b0};
  endtask : setpins
  task automatic fire(input int v);
    @(posedge core_clk);
    cmd_fire <= 1'b1;
    cmd_sample <= v[11:0];
    @(posedge core_clk);
    cmd_fire <= 1'b0;
    repeat (4) @(posedge core_clk);
    thr = ((v > up * 16) ? 128 : 0) | ((v < lo * 16) ? 64 : 0);
    lat_thr = lat_thr | thr;
  endtask : fire
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h41, 8'h00);
    rd(8'h42, 8'h00);
    rd(8'h43, 8'h00);
    rd(8'h4e, 8'hba);
    rd(8'h4f, 8'h4b);
    rd(8'h54, 8'h48);
    rd(8'h55, 8'h00);
    rd(8'h77, 8'h00);
    chk("supply_filter_select", 8'h02, {6'h00, sup_o});
    chk("battery_filter_select", 8'h02, {6'h00, bat_o});
    for (i = 0; i < 24; i++) begin
      p = 8'($random(seed));
      setpins(p);
      wr(8'h41, 8'hff);
      rd(8'h41, {p[7:4], 3'b000, p[3]});
      wr(8'h42, 8'hff);
      rd(8'h42, {4'h0, p[2:0], 1'b0});
      rd(8'h3a, lat_hs[7:0]);
      lat_hs = int'({p[2:0], 1'b0});
    end
    // Enable low: the write is not taken and the pins stay in the flops
    @(posedge core_clk);
    ce <= 1'b0;
    wr(8'h4e, 8'h00);
    setpins(~p);
    ce <= 1'b1;
    rd(8'h41, {p[7:4], 3'b000, p[3]});
    rd(8'h41, {~p[7:4], 3'b000, ~p[3]});
    rd(8'h4e, 8'hba);
    rd(8'h3a, lat_hs[7:0]);
    for (i = 0; i < 16; i++) begin
      s = $random(seed);
      up = s & 255;
      lo = (s >> 8) & 255;
      // Reserved bits are always written as their reset value
      flt = ((i % 4) << 5) | ((i / 4) << 2);
      dcfg = (s >> 16) & 3;
      wr_rd(8'h4e, up[7:0]);
      wr_rd(8'h4f, lo[7:0]);
      wr(8'h54, flt[7:0]);
      wr(8'h55, dcfg[7:0]);
      wr(8'h43, 8'hff);
      rd(8'h4e, up[7:0]);
      rd(8'h4f, lo[7:0]);
      rd(8'h54, flt[7:0]);
      chk("supply_filter_select", 8'(i % 4), {6'h00, sup_o});
      chk("battery_filter_select", 8'(i / 4), {6'h00, bat_o});
      chk("monitor_data_config", dcfg[7:0], dcfg_o);
      s = $random(seed) & 12'hfff;
      if (i % 4 == 1)
        s = up * 16;
      if (i % 4 == 2)
        s = lo * 16;
      if (i % 4 == 3)
        s = up * 16 + 1;
      fire(s);
      rd(8'h43, thr[7:0]);
      rd(8'h3b, lat_thr[7:0]);
      lat_thr = thr;
    end
    report_and_stop();
  end
  // Whole run is near 900 cycles; this leaves a wide margin
  initial begin
    #200000;
    fails++;
    report_and_stop();
  end
endmodule : diag_live_status_threshold_regs_tb_top
